// ---- design/fbsa_consts.vh ----
/*
  Constants of the fieldbus station address block: register offsets,
  field positions, reserved addresses, factory values and object indexes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FBSA_CONSTS_VH
`define FBSA_CONSTS_VH

// ****************************************************************
// Station addresses
// ****************************************************************
`define FBSA_ADDR_MIN 7'h01
`define FBSA_ADDR_MAX 7'h7d
`define FBSA_ADDR_TOOL 7'h00
`define FBSA_ADDR_DFLT 7'h7e
`define FBSA_ADDR_BCAST 7'h7f
`define FBSA_SW_ALL_ON 8'hff

// ****************************************************************
// Factory state of nonvolatile storage
// ****************************************************************
`define FBSA_NV_ADDR_RST 7'h7e
`define FBSA_NV_LOCK_RST 1'b0

// ****************************************************************
// APB register byte offsets
// ****************************************************************
`define FBSA_REG_STAT 12'h000
`define FBSA_REG_NVADR 12'h004
`define FBSA_REG_SWLIVE 12'h008
`define FBSA_REG_CNT 12'h00c

// ****************************************************************
// Field positions
// ****************************************************************
`define FBSA_STAT_FROM_NV 7
`define FBSA_STAT_LOCK 8
`define FBSA_STAT_XCHG 9
`define FBSA_STAT_SW_LSB 16
`define FBSA_NVADR_LOCK 8
`define FBSA_CNT_REF_LSB 8

// ****************************************************************
// Record object indexes
// ****************************************************************
`define FBSA_IDX_CTRL 8'h14
`define FBSA_IDX_STN 8'h40
`define FBSA_IDX_LOCK 8'h41
`define FBSA_IDX_USR_HI 4'h2
`define FBSA_CTRL_RST 8'h00

`endif

// ---- design/fbsa_nvstore.v ----
/*
  Nonvolatile holder of the assigned station address and change lock.
  Assumes factory_rstn is only asserted for a factory restore, never
  on an ordinary supply cycle, so both values outlive presetn.
*/
`timescale 1ns/100ps
`include "fbsa_consts.vh"

module fbsa_nvstore (
  input wire pclk,
  input wire factory_rstn,
  input wire wr_en,
  input wire [6:0] wr_addr,
  input wire set_lock,
  input wire clr_lock,
  output wire [6:0] nv_addr,
  output wire nv_lock
);

  reg [6:0] addr_ff;
  reg lock_ff;
  reg [6:0] nxt_addr;
  reg nxt_lock;

  // ****************************************************************
  // Next values
  // ****************************************************************
  always @*
  begin
    nxt_addr = addr_ff;
    nxt_lock = lock_ff;
    if (wr_en)
    begin
      nxt_addr = wr_addr;
    end
    if (set_lock)
    begin
      nxt_lock = 1'b1;
    end
    else if (clr_lock)
    begin
      nxt_lock = 1'b0;
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  // survives supply cycles
  always @(posedge pclk or negedge factory_rstn)
  begin
    if (!factory_rstn)
    begin
      addr_ff <= `FBSA_NV_ADDR_RST;
      lock_ff <= `FBSA_NV_LOCK_RST;
    end
    else
    begin
      addr_ff <= nxt_addr;
      lock_ff <= nxt_lock;
    end
  end

  assign nv_addr = addr_ff;
  assign nv_lock = lock_ff;

endmodule

// ---- design/fbsa_objlib.v ----
/*
  User record objects: sixteen 16-bit words at indexes 20h to 2Fh.
  Assumes the caller has checked slot and subslot and issues one
  access per cycle; answers combinationally for a registered caller.
*/
`timescale 1ns/100ps
`include "fbsa_consts.vh"

module fbsa_objlib (
  input wire pclk,
  input wire presetn,
  input wire acc_en,
  input wire acc_wr,
  input wire [7:0] acc_idx,
  input wire [15:0] acc_wdata,
  output wire acc_hit,
  output wire [15:0] acc_rdata
);

  reg [15:0] word_ff [0:15];
  wire sel;

  assign sel = (acc_idx[7:4] == `FBSA_IDX_USR_HI);
  assign acc_hit = sel;
  assign acc_rdata = word_ff[acc_idx[3:0]];

  // ****************************************************************
  // Word array
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_word
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          word_ff[gi] <= 16'h0000;
        end
        else if (acc_en && acc_wr && sel && (acc_idx[3:0] == gi))
        begin
          word_ff[gi] <= acc_wdata;
        end
      end
    end
  endgenerate

endmodule

// ---- design/fbsa_addr.v ----
/*
  Station address selection and record service of a fieldbus slave,
  with an APB register window for software.
  Assumes presetn is asserted on every supply power cycle, the switch
  bank and service requests are synchronous to pclk, and the link layer
  delivers decoded address-assignment and record requests as pulses.
*/
// The implementer's own choices: the APB interface to the registers and the register offsets.
// Operation
// - Only addresses 1 to 125 count as valid station addresses.
// - Address 0 is never adopted as our station address.
// - Address 126 is the default; data exchange waits for another one.
// - Address 127 is never adopted as our station address.
// - Switch address is weighted sum of switches one to seven.
// - Switch eight is ignored for the address, used only for unlock.
// - Switch value 0, 126 or 127 selects the stored address.
// - A changed switch address takes effect only after power cycle.
// - Assigned address is stored always, used only with reserved switches.
// - Once the change lock is set, later address changes are refused.
// - All eight switches on at power-up clear the change lock.
// - Factory state: switches off, address 126, lock clear.
// - Record read or write by index gets a record response.
// - Objects resolve by index only, given a valid slot and subslot.
`timescale 1ns/100ps
`include "fbsa_consts.vh"

module fbsa_addr (
  input wire pclk,
  input wire presetn,
  input wire factory_rstn,
  input wire [7:0] dip_sw,
  input wire ssa_req,
  input wire [6:0] ssa_addr,
  input wire ssa_lock,
  output reg ssa_ack,
  output reg ssa_ok,
  input wire rec_req,
  input wire rec_wr,
  input wire [7:0] rec_slot,
  input wire [7:0] rec_subslot,
  input wire [7:0] rec_index,
  input wire [15:0] rec_wdata,
  output reg rec_ack,
  output reg rec_ok,
  output reg [15:0] rec_rdata,
  output reg [6:0] station_addr,
  output reg addr_ready,
  output reg xchg_ok,
  output reg [7:0] ctrl_out,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr
);

  // ****************************************************************
  // Power-up sequencing states
  // ****************************************************************
  localparam ST_WAIT = 2'b00;
  localparam ST_CAPT = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] capt_sw_ff;
  reg from_nv_ff;
  reg [7:0] acc_cnt_ff;
  reg [7:0] ref_cnt_ff;
  reg [7:0] ctrl_ff;
  reg [15:0] obj_rdata;
  reg obj_hit;
  reg obj_ro;

  wire [6:0] nv_addr;
  wire nv_lock;
  wire [6:0] sw_addr;
  wire sw_reserved;
  wire ssa_addr_ok;
  wire ssa_take;
  wire apb_setup;
  wire apb_wr;
  wire apb_nv_ok;
  wire apb_nv_take;
  wire nv_wr_en;
  wire [6:0] nv_wr_addr;
  wire nv_clr;
  wire slot_ok;
  wire usr_hit;
  wire [15:0] usr_rdata;

  // ****************************************************************
  // Switch decode
  // ****************************************************************
  // binary weights 1 to 64
  assign sw_addr = dip_sw[6:0];

  assign sw_reserved = (sw_addr == `FBSA_ADDR_TOOL) ||
                       (sw_addr == `FBSA_ADDR_DFLT) ||
                       (sw_addr == `FBSA_ADDR_BCAST);

  // ****************************************************************
  // Nonvolatile storage
  // ****************************************************************
  // unlock only with all eight on at power-up
  assign nv_clr = (state_ff == ST_CAPT) &&
                  (dip_sw == `FBSA_SW_ALL_ON);

  // only 1 to 125 may be stored
  assign ssa_addr_ok = (ssa_addr >= `FBSA_ADDR_MIN) &&
                       (ssa_addr <= `FBSA_ADDR_MAX);

  assign ssa_take = ssa_req && (state_ff == ST_RUN) &&
                    !nv_lock && ssa_addr_ok;

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign apb_nv_ok = (pwdata[6:0] >= `FBSA_ADDR_MIN) &&
                     (pwdata[6:0] <= `FBSA_ADDR_MAX);

  // Assignment service beats a tool write in the same cycle
  // tool writes refused while locked
  assign apb_nv_take = apb_wr && (paddr == `FBSA_REG_NVADR) &&
                       apb_nv_ok && !nv_lock && !ssa_req &&
                       (state_ff == ST_RUN);

  assign nv_wr_en = ssa_take || apb_nv_take;
  assign nv_wr_addr = ssa_take ? ssa_addr : pwdata[6:0];

  fbsa_nvstore u_nv (
    .pclk(pclk),
    .factory_rstn(factory_rstn),
    .wr_en(nv_wr_en),
    .wr_addr(nv_wr_addr),
    .set_lock(ssa_take && ssa_lock),
    .clr_lock(nv_clr),
    .nv_addr(nv_addr),
    .nv_lock(nv_lock)
  );

  // ****************************************************************
  // Power-up sequencer
  // ****************************************************************
  // One settle cycle lets the switch bank be sampled after release
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_WAIT:
      begin
        nxt_state = ST_CAPT;
      end
      ST_CAPT:
      begin
        nxt_state = ST_RUN;
      end
      ST_RUN:
      begin
        nxt_state = ST_RUN;
      end
      default:
      begin
        nxt_state = ST_WAIT;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_WAIT;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Effective address, frozen until next supply cycle
  // ****************************************************************
  // default 126 until capture
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      station_addr <= `FBSA_ADDR_DFLT;
      from_nv_ff <= 1'b0;
      capt_sw_ff <= 8'h00;
      addr_ready <= 1'b0;
      xchg_ok <= 1'b0;
    end
    else if (state_ff == ST_CAPT)
    begin
      capt_sw_ff <= dip_sw;
      addr_ready <= 1'b1;
      if (sw_reserved)
      begin
        station_addr <= nv_addr;
        from_nv_ff <= 1'b1;
        // stored 126 still blocks data exchange
        xchg_ok <= (nv_addr >= `FBSA_ADDR_MIN) &&
                   (nv_addr <= `FBSA_ADDR_MAX);
      end
      else
      begin
        station_addr <= sw_addr;
        from_nv_ff <= 1'b0;
        // switch value here is already 1 to 125
        xchg_ok <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Assignment service answer and counters
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ssa_ack <= 1'b0;
      ssa_ok <= 1'b0;
      acc_cnt_ff <= 8'h00;
      ref_cnt_ff <= 8'h00;
    end
    else
    begin
      ssa_ack <= ssa_req;
      ssa_ok <= ssa_take;
      if (ssa_take)
      begin
        acc_cnt_ff <= acc_cnt_ff + 8'h01;
      end
      else if (ssa_req)
      begin
        ref_cnt_ff <= ref_cnt_ff + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Record service
  // ****************************************************************
  // slot and subslot must be nonzero, value otherwise ignored
  assign slot_ok = (rec_slot != 8'h00) && (rec_subslot != 8'h00);

  fbsa_objlib u_obj (
    .pclk(pclk),
    .presetn(presetn),
    .acc_en(rec_req && slot_ok),
    .acc_wr(rec_wr),
    .acc_idx(rec_index),
    .acc_wdata(rec_wdata),
    .acc_hit(usr_hit),
    .acc_rdata(usr_rdata)
  );

  always @*
  begin
    obj_hit = 1'b1;
    obj_ro = 1'b1;
    obj_rdata = 16'h0000;
    case (rec_index)
      `FBSA_IDX_CTRL:
      begin
        obj_ro = 1'b0;
        obj_rdata = {8'h00, ctrl_ff};
      end
      `FBSA_IDX_STN:
      begin
        obj_rdata = {9'h000, station_addr};
      end
      `FBSA_IDX_LOCK:
      begin
        obj_rdata = {15'h0000, nv_lock};
      end
      default:
      begin
        obj_hit = usr_hit;
        obj_ro = 1'b0;
        obj_rdata = usr_rdata;
      end
    endcase
  end

  // every request gets one response pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rec_ack <= 1'b0;
      rec_ok <= 1'b0;
      rec_rdata <= 16'h0000;
      ctrl_ff <= `FBSA_CTRL_RST;
    end
    else
    begin
      rec_ack <= rec_req;
      if (rec_req)
      begin
        rec_ok <= slot_ok && obj_hit && !(rec_wr && obj_ro);
        rec_rdata <= (slot_ok && obj_hit && !rec_wr) ? obj_rdata : 16'h0000;
        if (slot_ok && rec_wr && (rec_index == `FBSA_IDX_CTRL))
        begin
          ctrl_ff <= rec_wdata[7:0];
        end
      end
    end
  end

  always @*
  begin
    ctrl_out = ctrl_ff;
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Zero wait: read data is staged in the setup cycle
  assign pready = psel && penable;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      case (paddr)
        `FBSA_REG_STAT:
        begin
          prdata[6:0] <= station_addr;
          prdata[`FBSA_STAT_FROM_NV] <= from_nv_ff;
          prdata[`FBSA_STAT_LOCK] <= nv_lock;
          prdata[`FBSA_STAT_XCHG] <= xchg_ok;
          prdata[`FBSA_STAT_SW_LSB +: 8] <= capt_sw_ff;
          pslverr <= pwrite;
        end
        `FBSA_REG_NVADR:
        begin
          prdata[6:0] <= nv_addr;
          prdata[`FBSA_NVADR_LOCK] <= nv_lock;
          // Refusal decided now; an assignment in this cycle can still set the lock before access
          pslverr <= pwrite && (nv_lock || !apb_nv_ok ||
                     (state_ff != ST_RUN));
        end
        `FBSA_REG_SWLIVE:
        begin
          prdata[7:0] <= dip_sw;
          pslverr <= pwrite;
        end
        `FBSA_REG_CNT:
        begin
          prdata[7:0] <= acc_cnt_ff;
          prdata[`FBSA_CNT_REF_LSB +: 8] <= ref_cnt_ff;
          pslverr <= pwrite;
        end
        default:
        begin
          pslverr <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ---- test/fbsa_dp_master.sv ----
/*
  Behavioural bus master that issues address-assignment and record requests.
  Assumes the slave answers with one-cycle acknowledge pulses on pclk.
*/
`timescale 1ns/100ps
module fbsa_dp_master (
  input wire pclk,
  output reg ssa_req,
  output reg [6:0] ssa_addr,
  output reg ssa_lock,
  input wire ssa_ack,
  input wire ssa_ok,
  output reg rec_req,
  output reg rec_wr,
  output reg [7:0] rec_slot,
  output reg [7:0] rec_subslot,
  output reg [7:0] rec_index,
  output reg [15:0] rec_wdata,
  input wire rec_ack,
  input wire rec_ok,
  input wire [15:0] rec_rdata,
  output reg stalled
);
  // ****************************************************************
  // Requests
  // ****************************************************************
  initial
  begin
    {ssa_req, ssa_addr, ssa_lock, stalled} = '0;
    {rec_req, rec_wr, rec_slot, rec_subslot, rec_index, rec_wdata} = '0;
  end

  // the bench picks addresses, bad ones only on purpose
  task ssa(input logic [6:0] a, input logic lk, output logic ok);
    int n;
    begin
      @(posedge pclk);
      ssa_req <= 1'b1;
      ssa_addr <= a;
      ssa_lock <= lk;
      @(posedge pclk);
      ssa_req <= 1'b0;
      // Idle lines flip so a stale value is never mistaken for a request
      ssa_addr <= ~a;
      ssa_lock <= ~lk;
      n = 0;
      #1;
      while (ssa_ack !== 1'b1 && n < 8)
      begin
        @(posedge pclk);
        #1;
        n++;
      end
      stalled = stalled | (n == 8);
      ok = ssa_ok;
    end
  endtask

  // request names slot, subslot and index
  task rec(input logic wr, input logic [7:0] sl, input logic [7:0] ss,
           input logic [7:0] ix, input logic [15:0] wd, input int gap,
           output logic ok, output logic [15:0] rd);
    int n;
    begin
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      rec_req <= 1'b1;
      rec_wr <= wr;
      rec_slot <= sl;
      rec_subslot <= ss;
      rec_index <= ix;
      rec_wdata <= wd;
      @(posedge pclk);
      rec_req <= 1'b0;
      // Released lines show the inverse so a stale request cannot match
      rec_wr <= ~wr;
      rec_slot <= ~sl;
      rec_subslot <= ~ss;
      rec_index <= ~ix;
      rec_wdata <= ~wd;
      n = 0;
      #1;
      while (rec_ack !== 1'b1 && n < 8)
      begin
        @(posedge pclk);
        #1;
        n++;
      end
      stalled = stalled | (n == 8);
      ok = rec_ok;
      rd = rec_rdata;
    end
  endtask
endmodule

// ---- test/fbsa_addr_assertions.sv ----
/*
  Port checker for the station address block.
  Assumes a bind onto fbsa_addr, one clock, presetn as its reset.
*/
`timescale 1ns/100ps
module fbsa_addr_assertions (
  input wire pclk,
  input wire presetn,
  input wire [7:0] dip_sw,
  input wire ssa_req,
  input wire [6:0] ssa_addr,
  input wire ssa_ack,
  input wire ssa_ok,
  input wire rec_req,
  input wire rec_wr,
  input wire [7:0] rec_slot,
  input wire [7:0] rec_subslot,
  input wire [7:0] rec_index,
  input wire rec_ack,
  input wire rec_ok,
  input wire [6:0] station_addr,
  input wire addr_ready,
  input wire xchg_ok
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ssa_answer;
    ssa_req ##1 ssa_ack;
  endsequence
  sequence rec_answer;
    rec_req ##1 rec_ack;
  endsequence

  AST_SSA_ACK: assert property (ssa_req |-> ssa_answer)
    else $error("assignment not answered");
  AST_SSA_CAUSE: assert property (ssa_ack |-> $past(ssa_req))
    else $error("assignment answer without request");
  AST_SSA_RANGE: assert property (ssa_ack && ssa_ok |->
    $past(ssa_addr) >= 7'h01 && $past(ssa_addr) <= 7'h7d)
    else $error("out of range address accepted");
  AST_REC_ACK: assert property (rec_req |-> rec_answer)
    else $error("record request not answered");
  AST_REC_SLOT: assert property (rec_ack && rec_ok |->
    $past(rec_slot) != 8'h00 && $past(rec_subslot) != 8'h00)
    else $error("record accepted with zero slot");
  AST_REC_RO: assert property (rec_ack && $past(rec_wr) && $past(rec_index) == 8'h40
    |-> !rec_ok)
    else $error("station object written");
  AST_NO_RSV: assert property (addr_ready |->
    station_addr != 7'h00 && station_addr != 7'h7f)
    else $error("reserved station address adopted");
  AST_XCHG: assert property (addr_ready |->
    xchg_ok == (station_addr >= 7'h01 && station_addr <= 7'h7d))
    else $error("exchange flag wrong");
  AST_HOLD: assert property (addr_ready && $past(addr_ready) |-> $stable(station_addr))
    else $error("station address changed while running");
  AST_SW_ADDR: assert property ($rose(addr_ready) && $past(dip_sw[6:0]) >= 7'h01
    && $past(dip_sw[6:0]) <= 7'h7d |-> station_addr == $past(dip_sw[6:0]))
    else $error("switch address not adopted");
endmodule

// ---- test/fbsa_addr_tb_top.sv ----
/*
  Testbench of the station address block: APB tasks and master requests.
  Assumes the bus master model and the checker are compiled before it.
*/
`timescale 1ns/100ps
module fbsa_addr_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, factory_rstn = 1'b0;
  logic [7:0] dip_sw = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, ssa_req, ssa_lock, ssa_ack, ssa_ok, stalled;
  logic rec_req, rec_wr, rec_ack, rec_ok, addr_ready, xchg_ok;
  logic [6:0] ssa_addr, station_addr;
  logic [7:0] rec_slot, rec_subslot, rec_index, ctrl_out;
  logic [15:0] rec_wdata, rec_rdata;
  logic [31:0] prdata;
  int failures = 0, num_checks = 0;
  always #4 pclk = ~pclk;

  fbsa_addr dut_u (.pclk(pclk), .presetn(presetn), .factory_rstn(factory_rstn),
    .dip_sw(dip_sw), .ssa_req(ssa_req), .ssa_addr(ssa_addr), .ssa_lock(ssa_lock),
    .ssa_ack(ssa_ack), .ssa_ok(ssa_ok), .rec_req(rec_req), .rec_wr(rec_wr),
    .rec_slot(rec_slot), .rec_subslot(rec_subslot), .rec_index(rec_index),
    .rec_wdata(rec_wdata), .rec_ack(rec_ack), .rec_ok(rec_ok), .rec_rdata(rec_rdata),
    .station_addr(station_addr), .addr_ready(addr_ready), .xchg_ok(xchg_ok),
    .ctrl_out(ctrl_out), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  fbsa_dp_master mst_u (.pclk(pclk), .ssa_req(ssa_req), .ssa_addr(ssa_addr),
    .ssa_lock(ssa_lock), .ssa_ack(ssa_ack), .ssa_ok(ssa_ok), .rec_req(rec_req),
    .rec_wr(rec_wr), .rec_slot(rec_slot), .rec_subslot(rec_subslot),
    .rec_index(rec_index), .rec_wdata(rec_wdata), .rec_ack(rec_ack), .rec_ok(rec_ok),
    .rec_rdata(rec_rdata), .stalled(stalled));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task conclude;
    begin
      if (failures == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        failures++;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task hang(input logic stuck);
    begin
      if (stuck)
      begin
        failures++;
        conclude;
      end
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           input logic [31:0] exp, input logic experr);
    int n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'b1 && n < 8);
      hang(n == 8);
      if (!wr)
        chk(prdata, exp);
      chk({31'h0, pslverr}, {31'h0, experr});
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle bus shows the inverse so stale values are never reused
      paddr <= ~a;
      pwrite <= ~wr;
      pwdata <= ~wd;
    end
  endtask

  // Supply cycle: address and lock come back from storage
  task pwr(input logic [7:0] sw, input logic [6:0] exp);
    int n;
    begin
      @(posedge pclk);
      presetn <= 1'b0;
      dip_sw <= sw;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      factory_rstn <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        #1;
        n++;
      end
      while (addr_ready !== 1'b1 && n < 16);
      hang(n == 16);
      chk({25'h0, station_addr}, {25'h0, exp});
      chk({31'h0, xchg_ok}, {31'h0, exp != 7'h7e});
    end
  endtask

  task ssa(input logic [6:0] a, input logic lk, input logic exp);
    logic ok;
    begin
      mst_u.ssa(a, lk, ok);
      hang(stalled);
      chk({31'h0, ok}, {31'h0, exp});
    end
  endtask

  task rec(input logic wr, input logic [7:0] sl, input logic [7:0] ss, input logic [7:0] ix,
           input logic [15:0] wd, input logic exp, input logic [15:0] exprd);
    logic ok;
    logic [15:0] rd;
    begin
      mst_u.rec(wr, sl, ss, ix, wd, int'(sl), ok, rd);
      hang(stalled);
      chk({31'h0, ok}, {31'h0, exp});
      chk({16'h0000, rd}, {16'h0000, exprd});
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    pwr(8'h00, 7'h7e);
    rec(1'b0, 8'h01, 8'h01, 8'h40, 16'h0000, 1'b1, 16'h007e);
    pwr(8'h85, 7'h05);
    apb(1'b0, 12'h000, 32'h0, 32'h0085_0205, 1'b0);
    ssa(7'h00, 1'b0, 1'b0);
    ssa(7'h7f, 1'b0, 1'b0);
    ssa(7'h7e, 1'b0, 1'b0);
    ssa(7'h20, 1'b0, 1'b1);
    chk({25'h0, station_addr}, 32'h0000_0005);
    apb(1'b0, 12'h00c, 32'h0000_0000, 32'h0000_0301, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 32'h0000_0020, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'h0000_0000, 1'b1);
    pwr(8'h00, 7'h20);
    pwr(8'h7e, 7'h20);
    pwr(8'h7f, 7'h20);
    ssa(7'h30, 1'b1, 1'b1);
    ssa(7'h31, 1'b0, 1'b0);
    apb(1'b1, 12'h004, 32'h0000_0031, 32'h0, 1'b1);
    pwr(8'h00, 7'h30);
    apb(1'b0, 12'h004, 32'h0, 32'h0000_0130, 1'b0);
    pwr(8'hff, 7'h30);
    apb(1'b0, 12'h004, 32'h0, 32'h0000_0030, 1'b0);
    ssa(7'h31, 1'b0, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0022, 32'h0000_0000, 1'b0);
    apb(1'b0, 12'h004, 32'h0000_0000, 32'h0000_0022, 1'b0);
    apb(1'b1, 12'h004, 32'h0000_007e, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b0, 12'h008, 32'h0000_0000, 32'h0000_00ff, 1'b0);
    pwr(8'h80, 7'h22);
    rec(1'b0, 8'h00, 8'h01, 8'h40, 16'h0000, 1'b0, 16'h0000);
    rec(1'b0, 8'h05, 8'h09, 8'h41, 16'h0000, 1'b1, 16'h0000);
    rec(1'b1, 8'h01, 8'h01, 8'h20, 16'hbeef, 1'b1, 16'h0000);
    rec(1'b0, 8'h03, 8'h02, 8'h20, 16'h0000, 1'b1, 16'hbeef);
    rec(1'b1, 8'h01, 8'h01, 8'h40, 16'h0011, 1'b0, 16'h0000);
    rec(1'b1, 8'h01, 8'h01, 8'h14, 16'h005a, 1'b1, 16'h0000);
    chk({24'h0, ctrl_out}, 32'h0000_005a);
    conclude;
  end
endmodule

bind fbsa_addr fbsa_addr_assertions chk_u (.pclk(pclk), .presetn(presetn),
  .dip_sw(dip_sw), .ssa_req(ssa_req), .ssa_addr(ssa_addr), .ssa_ack(ssa_ack),
  .ssa_ok(ssa_ok), .rec_req(rec_req), .rec_wr(rec_wr), .rec_slot(rec_slot),
  .rec_subslot(rec_subslot), .rec_index(rec_index), .rec_ack(rec_ack), .rec_ok(rec_ok),
  .station_addr(station_addr), .addr_ready(addr_ready), .xchg_ok(xchg_ok));
